// *** rtl/sdp_addr_ctr.sv ***
/*
 * Per-port address register with load, advance, hold and clear.
 * Assumes its control inputs are synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module sdp_addr_ctr
    import sdp_pkg::*;
#(
    parameter int AW = sdp_pkg::SDP_AW
) (
    input  wire logic          clk,
    input  wire logic          rstn,
    input  wire logic          address_strobe_n,
    input  wire logic          counter_advance_enable_n,
    input  wire logic          counter_clear_n,
    input  wire logic [AW-1:0] ext_addr,
    output logic      [AW-1:0] addr_d,
    output logic      [AW-1:0] addr_q
);

    // Refuse an address width the package does not describe
    if (AW != SDP_AW) begin : g_bad_aw
        $error("sdp_addr_ctr: AW must equal the package address width");
    end

    // Decoded counter operations
    wire logic do_clear = !counter_clear_n;
    wire logic do_load  = counter_clear_n && !address_strobe_n;
    wire logic do_adv   = counter_clear_n && address_strobe_n
                          && !counter_advance_enable_n;

    // Address used at this edge; clear beats load beats advance
    assign addr_d = do_clear ? SDP_ADDR_RST :
                    do_load  ? ext_addr :
                    do_adv   ? addr_q + SDP_ADDR_STEP :
                               addr_q;

    // Held address, independent of enables and selects
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_q <= SDP_ADDR_RST;
        end else begin
            addr_q <= addr_d;
        end
    end

endmodule : sdp_addr_ctr

`default_nettype wire

// *** rtl/sdp_pkg.sv ***
/*
 * Shared constants and carriers for the synchronous dual-port RAM.
 * Assumes both ports and their bus masters share one clock domain.
 */
package sdp_pkg;

    // Geometry
    localparam int SDP_PORTS         = 2;
    localparam int SDP_DW            = 16;
    localparam int SDP_LANES         = 2;
    localparam int SDP_LANE_W        = 8;
    localparam int SDP_AW            = 15;
    localparam int SDP_DEPTH_DEEP    = 32768;
    localparam int SDP_DEPTH_SHALLOW = 16384;

    // Lane positions within a word
    localparam int SDP_LANE_LO = 0;
    localparam int SDP_LANE_HI = 1;

    // Values after reset and counter step
    localparam logic [SDP_AW-1:0] SDP_ADDR_RST  = 15'h0000;
    localparam logic [SDP_AW-1:0] SDP_ADDR_STEP = 15'h0001;
    localparam logic [SDP_DW-1:0] SDP_DATA_RST  = 16'h0000;

    // Output mode select levels
    localparam logic SDP_MODE_FLOW = 1'b0;
    localparam logic SDP_MODE_PIPE = 1'b1;

    // Pins of one port, as driven by its bus master
    typedef struct packed {
        logic                  chip_enable_low_active;
        logic                  chip_enable_high_active;
        logic                  upper_byte_select_n;
        logic                  lower_byte_select_n;
        logic                  read_write;
        logic                  output_enable_n;
        logic                  address_strobe_n;
        logic                  counter_advance_enable_n;
        logic                  counter_clear_n;
        logic                  output_mode_select;
        logic [SDP_AW-1:0]     addr;
        logic [SDP_DW-1:0]     dq_i;
    } sdp_port_in_t;

    // Data pins of one port, enable low while driving
    typedef struct packed {
        logic [SDP_DW-1:0]     dq_o;
        logic [SDP_LANES-1:0]  dq_oe_n;
    } sdp_port_out_t;

endpackage : sdp_pkg

// *** rtl/sdp_ram.sv ***
/*
 * Synchronous dual-port static RAM, two identical ports on one array.
 * Assumes each port's bus master is synchronous to clk and that the
 * two masters never write the same word in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module sdp_ram
    import sdp_pkg::*;
#(
    parameter int DEPTH = sdp_pkg::SDP_DEPTH_DEEP
) (
    input  wire logic                                 clk,
    input  wire logic                                 rstn,
    input  wire sdp_pkg::sdp_port_in_t  [SDP_PORTS-1:0] port_in,
    output sdp_pkg::sdp_port_out_t      [SDP_PORTS-1:0] port_out
);

    // Index width of the array; shallow variant drops the top bit
    localparam int IW = $clog2(DEPTH);

    // Refuse a depth other than the two variants
    if (DEPTH != SDP_DEPTH_DEEP && DEPTH != SDP_DEPTH_SHALLOW) begin : g_bad_depth
        $error("sdp_ram: DEPTH must be the deep or shallow size");
    end

    // Refuse a lane layout that does not fill the word
    if (SDP_DW != SDP_LANES * SDP_LANE_W) begin : g_bad_lanes
        $error("sdp_ram: lane layout does not fill the word");
    end

    // Lane enables from active-low upper and lower selects
    function automatic logic [SDP_LANES-1:0] lane_sel(
        input logic upper_n,
        input logic lower_n
    );
        logic [SDP_LANES-1:0] sel;
        sel              = '0;
        sel[SDP_LANE_HI] = !upper_n;
        sel[SDP_LANE_LO] = !lower_n;
        return sel;
    endfunction : lane_sel

    // Port selected when active-low enable low and active-high enable high
    function automatic logic port_sel(
        input logic en_low_active,
        input logic en_high_active
    );
        return !en_low_active && en_high_active;
    endfunction : port_sel

    // Shared storage of both ports
    logic [SDP_DW-1:0] mem [DEPTH];

    // Per-port write requests gathered for the single write process
    logic [IW-1:0]        wr_idx  [SDP_PORTS];
    logic [SDP_LANES-1:0] wr_lane [SDP_PORTS];
    logic [SDP_DW-1:0]    wr_data [SDP_PORTS];

    // Self-timed write of selected lanes at the capturing edge
    always_ff @(posedge clk) begin
        for (int p = 0; p < SDP_PORTS; p++) begin
            for (int l = 0; l < SDP_LANES; l++) begin
                if (wr_lane[p][l]) begin
                    mem[wr_idx[p]][l*SDP_LANE_W +: SDP_LANE_W]
                        <= wr_data[p][l*SDP_LANE_W +: SDP_LANE_W];
                end
            end
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < SDP_PORTS; gp++) begin : g_port

            // Pins of this port
            sdp_port_in_t pin;
            assign pin = port_in[gp];

            // Address used at this edge
            logic [SDP_AW-1:0] acc_addr;
            logic [SDP_AW-1:0] held_addr;

            sdp_addr_ctr #(
                .AW (SDP_AW)
            ) u_addr_ctr (
                .clk                      (clk),
                .rstn                     (rstn),
                .address_strobe_n         (pin.address_strobe_n),
                .counter_advance_enable_n (pin.counter_advance_enable_n),
                .counter_clear_n          (pin.counter_clear_n),
                .ext_addr                 (pin.addr),
                .addr_d                   (acc_addr),
                .addr_q                   (held_addr)
            );

            // Decode of this edge's controls
            wire logic [IW-1:0]        idx_now  = acc_addr[IW-1:0];
            wire logic                 sel_now  = port_sel(
                                           pin.chip_enable_low_active,
                                           pin.chip_enable_high_active);
            wire logic [SDP_LANES-1:0] lane_now = lane_sel(
                                           pin.upper_byte_select_n,
                                           pin.lower_byte_select_n);
            wire logic                 wr_now   = sel_now && !pin.read_write;
            wire logic                 rd_now   = sel_now && pin.read_write;

            // Write request; deselected port writes nothing
            assign wr_idx[gp]  = idx_now;
            assign wr_lane[gp] = wr_now ? lane_now : '0;
            assign wr_data[gp] = pin.dq_i;

            // Input and output register stages
            logic [SDP_LANES-1:0] lane1_q;
            logic                 rd1_q;
            logic                 rd2_q;
            logic                 mode_q;
            logic [SDP_DW-1:0]    data1_q;
            logic [SDP_DW-1:0]    data2_q;

            // Read of the array, old word on a same-edge write
            always_ff @(posedge clk) begin
                data1_q <= mem[idx_now];
            end

            // Control stages: selects once, chip enables per mode
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    lane1_q <= '0;
                    rd1_q   <= 1'b0;
                    rd2_q   <= 1'b0;
                    mode_q  <= SDP_MODE_FLOW;
                    data2_q <= SDP_DATA_RST;
                end else begin
                    lane1_q <= lane_now;
                    rd1_q   <= rd_now;
                    rd2_q   <= rd1_q;
                    mode_q  <= pin.output_mode_select;
                    data2_q <= data1_q;
                end
            end

            // Output selection by mode
            wire logic                 pipe     = (mode_q == SDP_MODE_PIPE);
            wire logic                 rd_out   = pipe ? rd2_q : rd1_q;
            wire logic [SDP_LANES-1:0] drive    = (rd_out && !pin.output_enable_n)
                                                  ? lane1_q : '0;

            // Pins; enable low while driving, oe acts without the clock
            assign port_out[gp].dq_o    = pipe ? data2_q : data1_q;
            assign port_out[gp].dq_oe_n = ~drive;
        end
    endgenerate

endmodule : sdp_ram

`default_nettype wire

// *** tb/sdp_master.sv ***
/* Bus master model for one RAM port, driving at the falling edge.
   Assumes the bench calls op once per cycle. */
`timescale 1ns/1ps
`default_nettype none
module sdp_master
    import sdp_pkg::*;
#(
    parameter logic MODE = sdp_pkg::SDP_MODE_FLOW
) (
    input  wire sdp_pkg::sdp_port_out_t dout,
    input  wire logic                   clk,
    output var  sdp_pkg::sdp_port_in_t  pin
);
    // Deselected and idle; mode pin never moves
    initial pin = {2'b10, 7'h7f, MODE, 31'h0};
    // One request; ctr 0 load, 1 step, 2 hold, 3 clear with all low
    task automatic op(input logic ce, input logic rw, input logic [1:0] bs_n,
                      input logic [1:0] ctr, input logic [14:0] a,
                      input logic [15:0] d, output sdp_port_out_t q);
        @(negedge clk);
        q = dout;
        pin.chip_enable_low_active = !ce;
        pin.chip_enable_high_active = ce;
        {pin.upper_byte_select_n, pin.lower_byte_select_n} = bs_n;
        pin.read_write = rw;
        pin.output_enable_n = 1'b0;
        pin.address_strobe_n = ctr[0] ^ ctr[1];
        pin.counter_advance_enable_n = !ctr[0];
        pin.counter_clear_n = (ctr != 2'h3);
        pin.addr = a;
        pin.dq_i = rw ? ~pin.dq_i : d; // Unused data keeps moving
    endtask : op
    // Output enable off; outputs seen before and after, no clock edge between
    task automatic oe_off(output sdp_port_out_t q_on, output sdp_port_out_t q);
        @(negedge clk);
        q_on = dout;
        pin.output_enable_n = 1'b1;
        #1 q = dout;
    endtask : oe_off
endmodule : sdp_master
`default_nettype wire

// *** tb/sdp_ram_properties.sv ***
/* Port assertions for the dual-port RAM.
   Assumes port 0 stays flow-through and port 1 pipelined. */
`timescale 1ns/1ps
`default_nettype none
module sdp_ram_properties
    import sdp_pkg::*;
(
    input wire logic                                   clk,
    input wire logic                                   rstn,
    input wire sdp_pkg::sdp_port_in_t  [SDP_PORTS-1:0] port_in,
    input wire sdp_pkg::sdp_port_out_t [SDP_PORTS-1:0] port_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Port selected
    function automatic logic sel(sdp_port_in_t p);
        return !p.chip_enable_low_active && p.chip_enable_high_active;
    endfunction : sel
    // Selected read of both lanes
    function automatic logic rd2(sdp_port_in_t p);
        return sel(p) && p.read_write && !p.upper_byte_select_n && !p.lower_byte_select_n;
    endfunction : rd2
    AST_OE_FLOAT: assert property (
        port_in[0].output_enable_n |-> port_out[0].dq_oe_n == 2'b11) else $error("oe high");
    AST_LANE_FLOW: assert property (
        (~port_out[0].dq_oe_n & $past({port_in[0].upper_byte_select_n,
        port_in[0].lower_byte_select_n})) == 2'b00) else $error("lane 0");
    AST_LANE_PIPE: assert property (
        (~port_out[1].dq_oe_n & $past({port_in[1].upper_byte_select_n,
        port_in[1].lower_byte_select_n})) == 2'b00) else $error("lane 1");
    AST_FLOW_DESEL: assert property (
        !port_in[0].output_mode_select && !sel($past(port_in[0]))
        |-> port_out[0].dq_oe_n == 2'b11) else $error("deselect flow");
    AST_FLOW_WR: assert property (
        !port_in[0].output_mode_select && sel($past(port_in[0])) && !$past(port_in[0].read_write)
        |-> port_out[0].dq_oe_n == 2'b11) else $error("write drives");
    AST_FLOW_DRIVE: assert property (
        !port_in[0].output_mode_select && rd2($past(port_in[0]))
        && !port_in[0].output_enable_n |-> port_out[0].dq_oe_n == 2'b00) else $error("flow read");
    AST_PIPE_DESEL: assert property (
        port_in[1].output_mode_select && !sel($past(port_in[1], 2))
        |-> port_out[1].dq_oe_n == 2'b11) else $error("deselect pipe");
    AST_PIPE_DRIVE: assert property (
        port_in[1].output_mode_select && $past(rstn, 3) && rd2($past(port_in[1], 2))
        && $past({port_in[1].upper_byte_select_n, port_in[1].lower_byte_select_n}) == 2'b00
        && !port_in[1].output_enable_n |-> port_out[1].dq_oe_n == 2'b00) else $error("pipe read");
endmodule : sdp_ram_properties
`default_nettype wire

// *** tb/test_sync_dual_port_ram_port.sv ***
/* Bench for the dual-port RAM: port 0 flow-through, port 1 pipelined.
   Assumes the master models and the property checker alongside. */
`timescale 1ns/1ps
`default_nettype none
module test_sync_dual_port_ram_port
    import sdp_pkg::*;
;
    localparam logic [1:0] LD = 2'h0, ADV = 2'h1, HLD = 2'h2, CLR = 2'h3;
    logic                          clk;
    logic                          rstn;
    wire sdp_port_in_t  [SDP_PORTS-1:0] port_in;
    wire sdp_port_out_t [SDP_PORTS-1:0] port_out;
    sdp_port_out_t                 q;
    sdp_port_out_t                 q1;
    sdp_port_out_t                 q2;
    int                            mismatches = 0;
    int                            samples_checked = 0;
    int                            cycles = 0;
    sdp_ram u_dut (.clk(clk), .rstn(rstn), .port_in(port_in), .port_out(port_out));
    sdp_master #(.MODE(SDP_MODE_FLOW)) u_m0 (.dout(port_out[0]), .clk(clk), .pin(port_in[0]));
    sdp_master #(.MODE(SDP_MODE_PIPE)) u_m1 (.dout(port_out[1]), .clk(clk), .pin(port_in[1]));
    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            stop_test();
        end
    end
    // Compare outputs; data only on lanes expected to drive
    task automatic chk(input sdp_port_out_t g, input logic [1:0] eo, input logic [15:0] ed);
        logic [15:0] m;
        m = {{8{~eo[1]}}, {8{~eo[0]}}};
        samples_checked++;
        if ({g.dq_oe_n, g.dq_o & m} !== {eo, ed & m}) begin
            mismatches++;
            $display("ERROR %0t: got %h/%h exp %h/%h", $time, g.dq_oe_n, g.dq_o, eo, ed);
        end
    endtask : chk
    // Byte lanes, top address bit, read right after write
    task automatic t_bytes();
        u_m0.op(1, 0, 2'b00, LD, 15'h7fff, 16'ha5a5, q);
        u_m0.op(1, 0, 2'b00, LD, 15'h3fff, 16'h5a5a, q);
        u_m0.op(1, 0, 2'b11, LD, 15'h3fff, 16'h0000, q);
        u_m0.op(1, 0, 2'b01, LD, 15'h3fff, 16'h99cc, q);
        u_m0.op(1, 0, 2'b10, LD, 15'h3fff, 16'h11ee, q);
        u_m0.op(1, 1, 2'b00, LD, 15'h3fff, 16'h0, q);
        u_m0.op(1, 1, 2'b01, LD, 15'h7fff, 16'h0, q);
        chk(q, 2'b00, 16'h99ee);
        u_m0.op(1, 1, 2'b10, LD, 15'h7fff, 16'h0, q);
        chk(q, 2'b01, 16'ha500);
        u_m0.op(1, 1, 2'b11, LD, 15'h7fff, 16'h0, q);
        chk(q, 2'b10, 16'h00a5);
        u_m0.op(0, 1, 2'b00, LD, 15'h7fff, 16'h0, q);
        chk(q, 2'b11, 16'h0);
        u_m0.op(0, 1, 2'b11, HLD, 15'h0, 16'h0, q);
        chk(q, 2'b11, 16'h0);
    endtask : t_bytes
    // Counter load, step while deselected, hold, clear over load
    task automatic t_counter();
        u_m0.op(1, 0, 2'b00, LD, 15'h0010, 16'hc0c0, q);
        u_m0.op(0, 0, 2'b00, ADV, 15'h0, 16'hdead, q);
        u_m0.op(1, 0, 2'b00, ADV, 15'h0, 16'hc2c2, q);
        u_m0.op(1, 0, 2'b00, HLD, 15'h7fff, 16'hc3c3, q);
        u_m0.op(1, 0, 2'b00, CLR, 15'h0012, 16'hc5c5, q);
        u_m0.op(1, 1, 2'b00, LD, 15'h0010, 16'h0, q);
        u_m0.op(1, 1, 2'b00, ADV, 15'h0, 16'h0, q);
        chk(q, 2'b00, 16'hc0c0);
        u_m0.op(1, 1, 2'b00, ADV, 15'h0, 16'h0, q);
        u_m0.op(1, 1, 2'b00, HLD, 15'h7fff, 16'h0, q);
        chk(q, 2'b00, 16'hc3c3);
        u_m0.op(1, 1, 2'b00, CLR, 15'h0012, 16'h0, q);
        chk(q, 2'b00, 16'hc3c3);
        u_m0.op(0, 1, 2'b11, HLD, 15'h0, 16'h0, q);
        chk(q, 2'b00, 16'hc5c5);
    endtask : t_counter
    // Both ports at once; pipelined latency, late deselect, output enable
    task automatic t_pipe();
        fork // Reads only, never one word written by both
            u_m0.op(1, 1, 2'b00, LD, 15'h7fff, 16'h0, q);
            u_m1.op(1, 1, 2'b00, LD, 15'h7fff, 16'h0, q1);
        join
        fork
            u_m0.op(1, 1, 2'b00, LD, 15'h3fff, 16'h0, q);
            u_m1.op(1, 1, 2'b00, LD, 15'h3fff, 16'h0, q1);
        join
        chk(q, 2'b00, 16'ha5a5);
        chk(q1, 2'b11, 16'h0);
        fork // Port 0 driving when its output enable rises
            u_m0.oe_off(q, q2);
            u_m1.op(0, 1, 2'b00, HLD, 15'h0, 16'h0, q1);
        join
        chk(q, 2'b00, 16'h99ee);
        chk(q2, 2'b11, 16'h0);
        chk(q1, 2'b00, 16'ha5a5);
        u_m1.op(0, 1, 2'b00, HLD, 15'h0, 16'h0, q1);
        chk(q1, 2'b00, 16'h99ee);
        u_m1.op(0, 1, 2'b11, HLD, 15'h0, 16'h0, q1);
        chk(q1, 2'b11, 16'h0);
    endtask : t_pipe
    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    // Reset, then scenarios
    initial begin
        rstn = 1'b0;
        repeat (12) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        t_bytes();
        t_counter();
        t_pipe();
        stop_test();
    end
endmodule : test_sync_dual_port_ram_port
bind sdp_ram sdp_ram_properties u_props (.clk(clk), .rstn(rstn), .port_in(port_in),
    .port_out(port_out));
`default_nettype wire
